// ==== inc/csc_pkg.sv ====
// package: constants for the cpu system control block
package csc_pkg;
	// register byte addresses
	localparam logic [15:0] CSC_ADDR_PORT2_FUNC   = 16'h_FF86;
	localparam logic [15:0] CSC_ADDR_STANDBY_EXCH = 16'h_FF8F;
	// standby/exchange field positions
	localparam int CSC_DRIVE_BIT  = 0;
	localparam int CSC_EXF_BIT    = 1;
	localparam int CSC_STBY_LO    = 2;
	localparam int CSC_STBY_HI    = 3;
	// port 2 function field positions
	localparam int CSC_EXT_BIT    = 0;
	localparam int CSC_NMI_PIN_FUNCTION_BIT   = 4;
	localparam int CSC_WAIT_LO    = 5;
	localparam int CSC_WAIT_HI    = 6;
	// reset values
	localparam logic [1:0] CSC_STBY_RESET = 2'h_0;
	localparam logic [1:0] CSC_WAIT_RESET = 2'h_0;
	localparam logic       CSC_BIT_RESET  = 1'b0;
	localparam logic [15:0] CSC_PC_RESET  = 16'h_0000;
	// memory map
	localparam logic [15:0] CSC_ROM_LO    = 16'h_0000;
	localparam logic [15:0] CSC_ROM_HI    = 16'h_0FFF;
	localparam logic [15:0] CSC_VEC_LO    = 16'h_0010;
	localparam logic [15:0] CSC_VEC_HI    = 16'h_005F;
	localparam logic [15:0] CSC_RAM_LO    = 16'h_FF00;
	localparam logic [15:0] CSC_RAM_HI    = 16'h_FF7F;
	localparam logic [15:0] CSC_DMA_LO    = 16'h_FF20;
	localparam logic [15:0] CSC_DMA_HI    = 16'h_FF5F;
	localparam logic [15:0] CSC_IO_LO     = 16'h_FF80;
	localparam logic [15:0] CSC_IO_HI     = 16'h_FF9F;
	// interrupts: vector = 8 * (index + 2), nmi index 1, maskable from 2
	localparam int CSC_NUM_SRC    = 10;
	localparam int CSC_VEC_STEP   = 8;
	localparam int CSC_VEC_BASE   = 16;
	// clock output divides oscillator by four: toggle every 2 osc cycles
	localparam int CSC_CLKOUT_DIV = 4;
	localparam int CSC_CLKOUT_HALF = CSC_CLKOUT_DIV / 2;
	// reset length in system clock cycles (party outside must hold)
	localparam int CSC_RESET_CYCLES = 10;
	// dummy bus cycles during vector read
	localparam int CSC_VEC_READ_CYCLES = 2;
	// standby modes
	typedef enum logic [1:0] {
		CSC_RUN   = 2'h_0,
		CSC_STOP  = 2'h_1,
		CSC_IDLE1 = 2'h_2,
		CSC_IDLE2 = 2'h_3
	} csc_standby_t;
endpackage

// ==== src/csc_addr_decode.sv ====
// module: internal address decoder for rom, ram, dma parameters and i/o
`timescale 1ns/10ps
module csc_addr_decode
	import csc_pkg::*;
(
	input  wire logic [15:0] addr,
	input  wire logic        rom_less,
	input  wire logic        dma_in_use,
	output logic             sel_rom,
	output logic             sel_vec_area,
	output logic             sel_ram,
	output logic             sel_dma_param,
	output logic             sel_io,
	output logic             sel_ext
);
	// region compare; rom-less parts push the low 4k out to the bus
	always_comb begin
		sel_rom       = !rom_less && addr <= CSC_ROM_HI;
		sel_vec_area  = addr >= CSC_VEC_LO && addr <= CSC_VEC_HI;
		sel_ram       = addr >= CSC_RAM_LO && addr <= CSC_RAM_HI;
		sel_dma_param = dma_in_use && addr >= CSC_DMA_LO && addr <= CSC_DMA_HI;
		sel_io        = addr >= CSC_IO_LO && addr <= CSC_IO_HI;
		sel_ext       = !(sel_rom || sel_ram || sel_io);
	end
endmodule // csc_addr_decode

// ==== src/csc_system_control.sv ====
// module: cpu system control: reset, control registers, decode, interrupt front end
//
// Contract
// - during reset every general port pin becomes input, high impedance.
// - read, write strobes and clock output driven high during reset.
// - reset clears program counter, enable flag and all control registers.
// - after reset the first fetch is from address zero.
// - pull-up pins stay pulled high through reset.
// - exchange toggle flag, bit 1 at FF8F, inverts on each bank swap.
// - wait select at bits 6:5 of port 2 function register, resets zero.
// - internal rom at 0000-0FFF; rom-less part routes it external.
// - 0010-005F is the interrupt handler entry area.
// - 128-byte ram decodes at FF00-FF7F, short direct reachable.
// - FF20-FF5F holds dma parameters when used, else plain ram.
// - 32-byte i/o space decodes at FF80-FF9F.
// - after reset all sources are general-purpose until dma enable set.
// - nmi always accepted; maskable only while enable flag is one.
// - requests sampled on clock output falling edge in last bus cycle.
// - accepting reads the vector from the interrupt controller.
// - after vector read, branch to general or dma handling.
// - vector read is internal; external bus shows dummy cycles.
// - clock output runs at quarter oscillator rate, toggling every 2 cycles, high in reset.
// - accepting any interrupt clears the enable flag.
`timescale 1ns/10ps
module csc_system_control
	import csc_pkg::*;
#(
	parameter int NUM_SRC = CSC_NUM_SRC
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                rom_less,
	// cpu register access port
	input  wire logic [15:0]         cpu_addr,
	input  wire logic [7:0]          cpu_wdata,
	input  wire logic                cpu_wr,
	input  wire logic                cpu_rd,
	output logic      [7:0]          cpu_rdata,
	// cpu sequencing events
	input  wire logic                register_bank_swap_instruction,
	input  wire logic                last_bus_cycle,
	input  wire logic                set_enable_flag,
	input  wire logic                clear_enable_flag,
	input  wire logic                branch_taken,
	input  wire logic [15:0]         branch_target,
	input  wire logic                pc_advance,
	// interrupt requests from controller (index 0 = soft, 1 = nmi)
	input  wire logic [NUM_SRC-1:0]  irq_req,
	input  wire logic [NUM_SRC-1:0]  dma_enable,
	// port pins
	input  wire logic [7:0]          port_in,
	input  wire logic [7:0]          port_out_val,
	input  wire logic [7:0]          port_dir_out,
	output logic      [7:0]          port_out,
	output logic      [7:0]          port_oe,
	output logic      [7:0]          port_pullup_en,
	output logic      [7:0]          port_in_sync,
	input  wire logic                strobe_rd_req,
	input  wire logic                strobe_wr_req,
	output logic                     read_strobe_pin,
	output logic                     write_strobe_pin,
	output logic                     clk_out,
	// state out
	output logic      [15:0]         pc,
	output logic                     interrupt_enable_flag,
	output logic                     exchange_toggle_flag,
	output logic      [1:0]          standby_select,
	output logic                     drive_in_stop,
	output logic      [1:0]          wait_state_select,
	output logic                     nmi_pin_function,
	output logic                     upper_address_pin_function,
	output logic                     irq_ack,
	output logic      [7:0]          irq_vector,
	output logic                     irq_to_dma,
	output logic                     bus_dummy_cycle,
	output logic      [5:0]          addr_region
);
	typedef enum logic [1:0] {CSC_IDLE, CSC_VEC_READ, CSC_DISPATCH} csc_irq_state_t;

	csc_irq_state_t                  state, next_state;
	logic [15:0]                     next_pc;
	logic                            next_interrupt_enable_flag;
	logic                            next_exchange_toggle_flag;
	logic [1:0]                      next_standby_select;
	logic                            next_drive_in_stop;
	logic [1:0]                      next_wait_state_select;
	logic                            next_nmi_pin_function;
	logic                            next_upper_address_pin_function;
	logic [7:0]                      next_cpu_rdata;
	logic [1:0]                      div_cnt, next_div_cnt;
	logic                            next_clk_out;
	logic                            clk_fall;
	logic [1:0]                      vec_cnt, next_vec_cnt;
	logic [3:0]                      src_idx, next_src_idx;
	logic                            next_irq_ack;
	logic [7:0]                      next_irq_vector;
	logic                            next_irq_to_dma;
	logic                            next_bus_dummy_cycle;
	logic [7:0]                      next_port_out, next_port_oe;
	logic                            next_read_strobe_pin, next_write_strobe_pin;
	logic [7:0]                      pin_s1, pin_s2, pin_s3;
	logic [7:0]                      next_port_in_sync;
	logic                            sel_rom, sel_vec, sel_ram, sel_dma, sel_io, sel_ext;
	logic [5:0]                      next_addr_region;
	logic [3:0]                      pick;
	logic                            pick_valid;

	csc_addr_decode u_decode (
		.addr          (cpu_addr),
		.rom_less      (rom_less),
		.dma_in_use    (|dma_enable),
		.sel_rom       (sel_rom),
		.sel_vec_area  (sel_vec),
		.sel_ram       (sel_ram),
		.sel_dma_param (sel_dma),
		.sel_io        (sel_io),
		.sel_ext       (sel_ext)
	);

	// highest-priority request: lower index wins; maskable gated by flag
	always_comb begin
		pick = 4'h_0;
		pick_valid = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (irq_req[i] && (i < 2 || interrupt_enable_flag)) begin
				pick = 4'(i);
				pick_valid = 1'b1;
			end
		end
	end

	// clock output divider, falling edge marks the sample point
	always_comb begin
		next_div_cnt = (div_cnt == 2'(CSC_CLKOUT_HALF - 1)) ? 2'h_0 : div_cnt + 2'h_1;
		next_clk_out = (div_cnt == 2'(CSC_CLKOUT_HALF - 1)) ? !clk_out : clk_out;
		clk_fall = (div_cnt == 2'(CSC_CLKOUT_HALF - 1)) && clk_out;
	end

	// interrupt acceptance sequence and cpu state
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_interrupt_enable_flag = interrupt_enable_flag;
		next_vec_cnt = vec_cnt;
		next_src_idx = src_idx;
		next_irq_ack = 1'b0;
		next_irq_vector = irq_vector;
		next_irq_to_dma = irq_to_dma;
		next_bus_dummy_cycle = 1'b0;
		if (branch_taken)
			next_pc = branch_target;
		else if (pc_advance)
			next_pc = pc + 16'h_0001;
		if (set_enable_flag)
			next_interrupt_enable_flag = 1'b1;
		if (clear_enable_flag)
			next_interrupt_enable_flag = 1'b0;
		unique case (state)
			CSC_IDLE: begin
				if (last_bus_cycle && clk_fall && pick_valid) begin
					next_state = CSC_VEC_READ;
					next_src_idx = pick;
					next_vec_cnt = 2'h_0;
					next_interrupt_enable_flag = 1'b0;
				end
			end
			CSC_VEC_READ: begin
				// vector comes from inside; the bus only idles
				next_bus_dummy_cycle = 1'b1;
				next_vec_cnt = vec_cnt + 2'h_1;
				if (vec_cnt == 2'(CSC_VEC_READ_CYCLES - 1)) begin
					next_irq_vector = 8'(CSC_VEC_BASE + CSC_VEC_STEP * int'(src_idx));
					next_irq_ack = 1'b1;
					next_state = CSC_DISPATCH;
				end
			end
			CSC_DISPATCH: begin
				// soft and nmi never go to dma; others only if enabled
				next_irq_to_dma = src_idx >= 4'h_2 && dma_enable[src_idx];
				if (!next_irq_to_dma)
					next_pc = {8'h_00, irq_vector};
				next_state = CSC_IDLE;
			end
		endcase
	end

	// register writes, read data and exchange flag
	always_comb begin
		next_exchange_toggle_flag = exchange_toggle_flag;
		next_standby_select = standby_select;
		next_drive_in_stop = drive_in_stop;
		next_wait_state_select = wait_state_select;
		next_nmi_pin_function = nmi_pin_function;
		next_upper_address_pin_function = upper_address_pin_function;
		next_cpu_rdata = 8'h_00;
		if (register_bank_swap_instruction)
			next_exchange_toggle_flag = !exchange_toggle_flag;
		if (cpu_wr && cpu_addr == CSC_ADDR_STANDBY_EXCH) begin
			next_standby_select = cpu_wdata[CSC_STBY_HI:CSC_STBY_LO];
			next_drive_in_stop = cpu_wdata[CSC_DRIVE_BIT];
		end
		if (cpu_wr && cpu_addr == CSC_ADDR_PORT2_FUNC) begin
			next_wait_state_select = cpu_wdata[CSC_WAIT_HI:CSC_WAIT_LO];
			next_nmi_pin_function = cpu_wdata[CSC_NMI_PIN_FUNCTION_BIT];
			next_upper_address_pin_function = cpu_wdata[CSC_EXT_BIT];
		end
		if (cpu_rd && cpu_addr == CSC_ADDR_STANDBY_EXCH) begin
			next_cpu_rdata[CSC_STBY_HI:CSC_STBY_LO] = standby_select;
			next_cpu_rdata[CSC_EXF_BIT] = exchange_toggle_flag;
			next_cpu_rdata[CSC_DRIVE_BIT] = drive_in_stop;
		end
		// write-only address bit reads zero, hence no read-modify-write
		if (cpu_rd && cpu_addr == CSC_ADDR_PORT2_FUNC) begin
			next_cpu_rdata[CSC_WAIT_HI:CSC_WAIT_LO] = wait_state_select;
			next_cpu_rdata[CSC_NMI_PIN_FUNCTION_BIT] = nmi_pin_function;
		end
	end

	// pin drive; reset alone forces the safe levels
	always_comb begin
		next_port_out = port_out_val;
		next_port_oe = port_dir_out;
		next_read_strobe_pin = !strobe_rd_req;
		next_write_strobe_pin = !strobe_wr_req;
		next_addr_region = {sel_ext, sel_io, sel_dma, sel_ram, sel_vec, sel_rom};
		// per bit: a pin that still bounces must not hold back its neighbours
		next_port_in_sync = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & port_in_sync);
	end

	// pin input synchroniser: first stage feeds only the second
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_s1 <= 8'h_FF;
			pin_s2 <= 8'h_FF;
			pin_s3 <= 8'h_FF;
			port_in_sync <= 8'h_FF;
		end else begin
			pin_s1 <= port_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			port_in_sync <= next_port_in_sync;
		end
	end

	// pins and decode registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_out <= 8'h_00;
			port_oe <= 8'h_00;
			port_pullup_en <= 8'h_FF;
			read_strobe_pin <= 1'b1;
			write_strobe_pin <= 1'b1;
			clk_out <= 1'b1;
			div_cnt <= 2'h_0;
			addr_region <= 6'h_00;
		end else begin
			port_out <= next_port_out;
			port_oe <= next_port_oe;
			port_pullup_en <= ~port_dir_out;
			read_strobe_pin <= next_read_strobe_pin;
			write_strobe_pin <= next_write_strobe_pin;
			clk_out <= next_clk_out;
			div_cnt <= next_div_cnt;
			addr_region <= next_addr_region;
		end
	end

	// cpu state and interrupt sequence registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= CSC_IDLE;
			pc <= CSC_PC_RESET;
			interrupt_enable_flag <= CSC_BIT_RESET;
			vec_cnt <= 2'h_0;
			src_idx <= 4'h_0;
			irq_ack <= 1'b0;
			irq_vector <= 8'h_00;
			irq_to_dma <= 1'b0;
			bus_dummy_cycle <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			interrupt_enable_flag <= next_interrupt_enable_flag;
			vec_cnt <= next_vec_cnt;
			src_idx <= next_src_idx;
			irq_ack <= next_irq_ack;
			irq_vector <= next_irq_vector;
			irq_to_dma <= next_irq_to_dma;
			bus_dummy_cycle <= next_bus_dummy_cycle;
		end
	end

	// control registers; exchange flag is undefined at reset, zero chosen
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			exchange_toggle_flag <= CSC_BIT_RESET;
			standby_select <= CSC_STBY_RESET;
			drive_in_stop <= CSC_BIT_RESET;
			wait_state_select <= CSC_WAIT_RESET;
			nmi_pin_function <= CSC_BIT_RESET;
			upper_address_pin_function <= CSC_BIT_RESET;
			cpu_rdata <= 8'h_00;
		end else begin
			exchange_toggle_flag <= next_exchange_toggle_flag;
			standby_select <= next_standby_select;
			drive_in_stop <= next_drive_in_stop;
			wait_state_select <= next_wait_state_select;
			nmi_pin_function <= next_nmi_pin_function;
			upper_address_pin_function <= next_upper_address_pin_function;
			cpu_rdata <= next_cpu_rdata;
		end
	end
endmodule // csc_system_control

// ==== tb/csc_checker.sv ====
// checker: port-level properties of the cpu system control block
`timescale 1ns/10ps
module csc_checker
	import csc_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        rom_less,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0]  cpu_wdata,
	input wire logic        cpu_wr,
	input wire logic        register_bank_swap_instruction,
	input wire logic [7:0]  port_oe,
	input wire logic [7:0]  port_pullup_en,
	input wire logic        read_strobe_pin,
	input wire logic        write_strobe_pin,
	input wire logic        clk_out,
	input wire logic [15:0] pc,
	input wire logic        interrupt_enable_flag,
	input wire logic        exchange_toggle_flag,
	input wire logic [1:0]  standby_select,
	input wire logic        drive_in_stop,
	input wire logic [1:0]  wait_state_select,
	input wire logic        nmi_pin_function,
	input wire logic        upper_address_pin_function,
	input wire logic        irq_ack,
	input wire logic [7:0]  irq_vector,
	input wire logic        irq_to_dma,
	input wire logic        bus_dummy_cycle,
	input wire logic [5:0]  addr_region
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// vector read: two dummy bus cycles, the vector handed over on the second
	sequence s_vec_read;
		bus_dummy_cycle ##1 (bus_dummy_cycle && irq_ack);
	endsequence
	sequence s_vec_start;
		$rose(bus_dummy_cycle) && !interrupt_enable_flag;
	endsequence
	// state seen at the first edge after release is what reset left behind
	chk_reset_state: assert property ($fell(reset) |-> port_oe == 8'h_00 && port_pullup_en == 8'h_ff
		&& read_strobe_pin && write_strobe_pin && clk_out && pc == CSC_PC_RESET
		&& !interrupt_enable_flag) else $error("pin or cpu state wrong after reset");
	chk_clkout_rate: assert property (!$stable(clk_out) |=> $stable(clk_out) ##1 !$stable(clk_out))
		else $error("clock output not at quarter rate");
	chk_swap_toggle: assert property (register_bank_swap_instruction |=>
		exchange_toggle_flag != $past(exchange_toggle_flag)) else $error("exchange flag not inverted");
	chk_port2_write: assert property (cpu_wr && cpu_addr == CSC_ADDR_PORT2_FUNC |=>
		wait_state_select == $past(cpu_wdata[6:5]) && nmi_pin_function == $past(cpu_wdata[4])
		&& upper_address_pin_function == $past(cpu_wdata[0])) else $error("port 2 function write lost");
	chk_standby_write: assert property (cpu_wr && cpu_addr == CSC_ADDR_STANDBY_EXCH |=>
		standby_select == $past(cpu_wdata[3:2]) && drive_in_stop == $past(cpu_wdata[0]))
		else $error("standby write lost");
	chk_vector_fetch: assert property (s_vec_start |-> s_vec_read)
		else $error("vector read sequence wrong");
	chk_vector_range: assert property (irq_ack |-> irq_vector >= 8'h_10 && irq_vector <= 8'h_58)
		else $error("vector outside entry area");
	chk_mask_honoured: assert property (irq_ack |-> irq_vector < 8'h_20
		|| $past(interrupt_enable_flag, 3)) else $error("masked request accepted");
	chk_general_branch: assert property (irq_ack |=> irq_to_dma || pc == {8'h_00, $past(irq_vector)})
		else $error("general handler not entered");
	chk_rom_decode: assert property (cpu_addr <= CSC_ROM_HI |=> addr_region[0] != $past(rom_less))
		else $error("rom decode wrong");
	chk_ram_decode: assert property (cpu_addr inside {[CSC_RAM_LO:CSC_RAM_HI]} |=> addr_region[2])
		else $error("ram decode wrong");
	chk_io_decode: assert property (cpu_addr inside {[CSC_IO_LO:CSC_IO_HI]} |=> addr_region[4])
		else $error("io decode wrong");
endmodule // csc_checker

bind csc_system_control csc_checker u_chk (.*);

// ==== tb/csc_partner.sv ====
// partner model: pins and parts outside the device on the port lines
`timescale 1ns/10ps
module csc_partner (
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe,
	input wire logic [7:0] port_pullup_en,
	input wire logic [7:0] ext_drv,
	input wire logic [7:0] ext_val,
	output logic     [7:0] port_in
);
	// device drive wins, then an outside driver, then the pull-up; a floating pin
	// without pull-up shows the inverse of the last output so it never looks held
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (port_oe[i]) port_in[i] = port_out[i];
			else if (ext_drv[i]) port_in[i] = ext_val[i];
			else port_in[i] = port_pullup_en[i] | ~port_out[i];
		end
	end
endmodule // csc_partner

// ==== tb/testbench.sv ====
// testbench: register, pin, decode and interrupt tests of the system control block
`timescale 1ns/10ps
module testbench;
	import csc_pkg::*;
	logic clk, reset, rom_less, cpu_wr, cpu_rd, register_bank_swap_instruction, last_bus_cycle;
	logic set_enable_flag, clear_enable_flag, branch_taken, pc_advance, strobe_rd_req, strobe_wr_req;
	logic read_strobe_pin, write_strobe_pin, clk_out, interrupt_enable_flag, exchange_toggle_flag;
	logic drive_in_stop, nmi_pin_function, upper_address_pin_function, irq_ack, irq_to_dma;
	logic        bus_dummy_cycle;
	logic [15:0] cpu_addr, branch_target, pc;
	logic [7:0]  cpu_wdata, cpu_rdata, port_in, port_out_val, port_dir_out, port_out, port_oe;
	logic [7:0]  port_pullup_en, port_in_sync, irq_vector, ext_drv, ext_val;
	logic [9:0]  irq_req, dma_enable;
	logic [1:0]  standby_select, wait_state_select;
	logic [5:0]  addr_region;
	int          err_count, n_tests;
	// decode probes: address, region bit, expected bit (dma area not in use yet)
	logic [15:0] da [11] = '{16'h_0000, 16'h_0FFF, 16'h_1000, 16'h_0010, 16'h_005F,
		16'h_FF00, 16'h_FF7F, 16'h_FF80, 16'h_FF9F, 16'h_FFA0, 16'h_FF20};
	int          db [11] = '{0, 0, 0, 1, 1, 2, 2, 4, 4, 4, 3};
	logic        de [11] = '{1, 1, 0, 1, 1, 1, 1, 1, 1, 0, 0};

	csc_system_control u_dut (.*);
	csc_partner u_partner (.*);

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) begin
			cpu_addr <= a; cpu_wdata <= d; cpu_wr <= 1;
		end
		@(posedge clk) cpu_wr <= 0;
	endtask

	// read data stands one cycle, so it is taken just after the answering edge
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string name);
		@(posedge clk) begin
			cpu_addr <= a; cpu_rd <= 1;
		end
		@(posedge clk) cpu_rd <= 0;
		#1 chk(name, cpu_rdata, e);
	endtask

	task automatic pulse_enable();
		@(posedge clk) set_enable_flag <= 1;
		@(posedge clk) set_enable_flag <= 0;
	endtask

	// the source drops its request once the vector read has begun
	task automatic irq(input int src, input logic [7:0] ev, input logic dma);
		int i;
		@(posedge clk) irq_req[src] <= 1;
		for (i = 0; i < 80 && bus_dummy_cycle !== 1; i++) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk) irq_req[src] <= 0;
		#1 chk("irq_ack", irq_ack, 1);
		chk("irq_vector", irq_vector, ev);
		chk("bus_dummy_cycle", bus_dummy_cycle, 1);
		chk("enable_flag", interrupt_enable_flag, 0);
		@(posedge clk);
		#1 chk("irq_to_dma", irq_to_dma, dma);
		if (!dma) chk("pc", pc, {8'h_00, ev});
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// watchdog: the tests need about two hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done();
	end

	initial begin
		logic        p;
		int          t;
		{cpu_wr, cpu_rd, register_bank_swap_instruction, clear_enable_flag} = '0;
		{branch_taken, pc_advance, rom_less, irq_req, dma_enable} = '0;
		{cpu_addr, branch_target, cpu_wdata, ext_drv, ext_val} = '0;
		{set_enable_flag, strobe_rd_req, strobe_wr_req, last_bus_cycle} = '1;
		port_out_val = 8'h_a5;
		port_dir_out = 8'h_ff;
		reset = 1;
		// reset held thirteen clock edges with pins asking to drive
		repeat (6) @(posedge clk);
		#1 chk("port_oe", port_oe, 8'h_00);
		chk("pullup", port_pullup_en, 8'h_ff);
		chk("strobes", {read_strobe_pin, write_strobe_pin}, 2'b11);
		chk("clk_out", clk_out, 1);
		chk("pc", pc, CSC_PC_RESET);
		chk("enable_flag", interrupt_enable_flag, 0);
		repeat (6) @(posedge clk);
		@(posedge clk) begin
			reset <= 0; set_enable_flag <= 0; port_dir_out <= 8'h_0f;
			strobe_rd_req <= 0; strobe_wr_req <= 0; ext_drv <= 8'h_80;
		end
		#1 chk("pc", pc, 16'h_0000);
		@(posedge clk) pc_advance <= 1;
		@(posedge clk) begin
			pc_advance <= 0; branch_taken <= 1; branch_target <= 16'h_0123;
		end
		#1 chk("pc", pc, 16'h_0001);
		@(posedge clk) branch_taken <= 0;
		#1 chk("pc", pc, 16'h_0123);
		$display("reset test finished");
		rdchk(CSC_ADDR_PORT2_FUNC, 8'h_00, "port2_func");
		rdchk(CSC_ADDR_STANDBY_EXCH, 8'h_00, "standby_exch");
		wr(CSC_ADDR_PORT2_FUNC, 8'h_71);
		rdchk(CSC_ADDR_PORT2_FUNC, 8'h_70, "port2_func");
		chk("upper_address", upper_address_pin_function, 1);
		wr(CSC_ADDR_STANDBY_EXCH, 8'h_0f);
		rdchk(CSC_ADDR_STANDBY_EXCH, 8'h_0d, "standby_exch");
		for (int m = 0; m < 4; m++) begin
			wr(CSC_ADDR_STANDBY_EXCH, 8'(m << 2));
			#1 chk("standby_select", standby_select, 16'(m));
		end
		wr(16'h_FF9E, 8'h_ff);
		rdchk(16'h_FF9E, 8'h_00, "unmapped");
		rdchk(CSC_ADDR_PORT2_FUNC, 8'h_70, "port2_func");
		@(posedge clk) register_bank_swap_instruction <= 1;
		@(posedge clk) register_bank_swap_instruction <= 0;
		rdchk(CSC_ADDR_STANDBY_EXCH, 8'h_0e, "standby_exch");
		@(posedge clk) register_bank_swap_instruction <= 1;
		repeat (2) @(posedge clk);
		register_bank_swap_instruction <= 0;
		rdchk(CSC_ADDR_STANDBY_EXCH, 8'h_0e, "standby_exch");
		$display("register test finished");
		// upper pins released: pulled high except the one held low outside
		#1 chk("port_oe", port_oe, 8'h_0f);
		chk("port_out", port_out, 8'h_a5);
		chk("port_in_sync", port_in_sync, 8'h_75);
		// strobe pins follow their requests, active low, one cycle later
		@(posedge clk) strobe_rd_req <= 1;
		@(posedge clk) strobe_rd_req <= 0;
		#1 chk("strobes", {read_strobe_pin, write_strobe_pin}, 2'b01);
		p = clk_out;
		t = 0;
		repeat (16) begin
			@(posedge clk);
			#1 if (clk_out !== p) t++;
			p = clk_out;
		end
		chk("clk_out_toggles", 16'(t), 16'd8);
		for (int k = 0; k < 11; k++) begin
			@(posedge clk) cpu_addr <= da[k];
			@(posedge clk);
			#1 chk("addr_region", addr_region[db[k]], de[k]);
		end
		@(posedge clk) begin
			rom_less <= 1; cpu_addr <= 16'h_0000;
		end
		@(posedge clk);
		#1 chk("rom_less_region", {addr_region[5], addr_region[0]}, 2'b10);
		@(posedge clk) rom_less <= 0;
		$display("decode test finished");
		@(posedge clk) clear_enable_flag <= 1;
		@(posedge clk) begin
			clear_enable_flag <= 0; irq_req[2] <= 1;
		end
		t = 0;
		repeat (40) begin
			@(posedge clk);
			#1 if (bus_dummy_cycle !== 0) t++;
		end
		chk("masked_accepts", 16'(t), 16'd0);
		pulse_enable();
		irq(2, 8'h_20, 0);
		// a request outside the last bus cycle of an instruction must wait
		@(posedge clk) begin
			last_bus_cycle <= 0; irq_req[1] <= 1;
		end
		t = 0;
		repeat (20) begin
			@(posedge clk);
			#1 if (bus_dummy_cycle !== 0) t++;
		end
		chk("mid_instr_accepts", 16'(t), 16'd0);
		@(posedge clk) last_bus_cycle <= 1;
		irq(1, 8'h_18, 0);
		@(posedge clk) dma_enable[3] <= 1;
		pulse_enable();
		irq(3, 8'h_28, 1);
		chk("pc", pc, 16'h_0018);
		// with a source on dma the parameter area is marked as such
		@(posedge clk) cpu_addr <= 16'h_FF20;
		@(posedge clk);
		#1 chk("dma_region", addr_region[3:2], 2'b11);
		$display("interrupt test finished");
		test_done();
	end
endmodule // testbench
